// [verilog/ssr_pkg.sv]
package ssr_pkg;
  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25000000; // System clock rate
  localparam int unsigned TICK_US = 1000; // Ramp tick period in microseconds
  localparam int unsigned TICK_CYC = (CLK_HZ / 1000000) * TICK_US; // Cycles per tick
  localparam int unsigned TICKS_PER_S = 1000000 / TICK_US; // Ticks per second
  // ---------------------------------------------------------------
  // Level scaling: voltage references are 16-bit fractions, current references 10.6 percent
  // ---------------------------------------------------------------
  localparam int unsigned LVL_W = 16; // Reference width
  localparam logic [15:0] LVL_FULL = 16'hffff; // Full output voltage
  localparam logic [15:0] LVL_ZERO = 16'h0000; // Output off
  localparam logic [9:0] PCT_FULL = 10'h064; // 100 percent
  localparam logic [9:0] CL_MIN_PCT = 10'h0c8; // Lowest current limit, 200 percent
  localparam logic [9:0] CL_MAX_PCT = 10'h258; // Limit disabled, 600 percent
  // ---------------------------------------------------------------
  // Ramp profile codes
  // ---------------------------------------------------------------
  localparam logic [3:0] PROF_V1 = 4'h1; // Voltage ramp
  localparam logic [3:0] PROF_C2 = 4'h2; // Current ramp
  localparam logic [3:0] PROF_V3 = 4'h3; // Voltage ramp
  localparam logic [3:0] PROF_C4 = 4'h4; // Current ramp
  // ---------------------------------------------------------------
  // Decel settings and other register defaults
  // ---------------------------------------------------------------
  localparam logic [1:0] DM_OFF = 2'h0; // No decel
  localparam logic [1:0] DM_PROT = 2'h1; // Decel, coast on trip
  localparam logic [1:0] DM_FORCE = 2'h2; // Decel through trip
  localparam logic [6:0] DBEG_DEF = 7'h3c; // Begin level default 60
  localparam logic [6:0] DOFF_DEF = 7'h1e; // Shut-off default 30
  localparam logic [5:0] DTIME_DEF = 6'h0a; // Decel time default 10 s
  localparam logic [5:0] DTIME_MIN = 6'h01; // Decel time floor
  localparam logic [5:0] DTIME_MAX = 6'h3c; // Decel time ceiling
  localparam logic [6:0] ATIME_DEF = 7'h0a; // Accel time default 10 s
  localparam logic [15:0] IV_DEF = 16'h2000; // Initial voltage default
  localparam logic [9:0] IC_DEF = 10'h064; // Initial current default
  localparam logic [9:0] CL_DEF = 10'h15e; // Current limit default 350
  // ---------------------------------------------------------------
  // Wishbone register map, word offsets as byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00; // Run, stop, profile
  localparam logic [7:0] A_INIT = 8'h04; // Initial voltage and current
  localparam logic [7:0] A_ACCEL = 8'h08; // Accel time and current limit
  localparam logic [7:0] A_DECEL = 8'h0c; // Decel mode, levels, time
  localparam logic [7:0] A_STAT = 8'h10; // State and flags
  localparam logic [7:0] A_REF = 8'h14; // Live references
  // Field positions
  localparam int unsigned F_RUN = 0; // Run command bit
  localparam int unsigned F_STOP = 1; // Stop pulse bit
  localparam int unsigned F_PROF = 4; // Profile field low bit
  // ---------------------------------------------------------------
  // Controller state
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SSR_IDLE,
    SSR_RAMP,
    SSR_LIMIT,
    SSR_RUN,
    SSR_DECEL
  } ssr_state_e;
endpackage : ssr_pkg

// [verilog/ssr_top.sv]
// Overview of operation
// - Codes 1,3 voltage ramp; 2,4 current ramp
// - Limit at maximum disables current limiting
// - Ramp begins at programmed initial level
// - Ramp time bounds climb to limit/full
// - Voltage ramp: limit overrides ramp time
// - At-speed cuts ramp short
// - Current held at or below limit
// - Limit active until at-speed or trip
// - Voltage rises until limit current reached
// - Current ramp: closed loop linear rise
// - Limit setpoint not below 200 percent
// - No timeout while at current limit
// - Stop starts decel, opens bypass immediately
// - Decel mode 0..2, default 0, 0 off
// - Mode 1: trip during decel coasts
// - Mode 2: decel completes despite trip
// - Begin level 0..100, default 60, first drop
// - Shut-off 0..begin-1, default 30, ends decel
// - Decel time 1..60 s, default 10
`timescale 1ns/100ps
`default_nettype none
module ssr_top #(
  parameter int unsigned TICK_CYCLES = ssr_pkg::TICK_CYC // Tick length, shortenable
) (
  input wire logic mclk_i, // 25 MHz clock
  input wire logic rst_n_i, // Async reset, active low
  input wire logic [7:0] wb_adr_i, // Wishbone address
  input wire logic [31:0] wb_dat_i, // Write data
  input wire logic [3:0] wb_sel_i, // Byte lanes
  input wire logic wb_we_i, // Write enable
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  input wire logic at_speed_i, // At-speed pin
  input wire logic overload_i, // Overload trip pin
  input wire logic [9:0] motor_cur_i, // Measured current, percent of motor
  output logic [15:0] volt_ref_o, // Output voltage reference
  output logic fire_en_o, // Thyristors firing
  output logic bypass_o // Bypass contactor closed
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] spd_s; // At-speed synchroniser
    logic [1:0] ol_s; // Overload synchroniser
    logic ack; // Bus acknowledge
    logic [31:0] rdat; // Read data
    logic run; // Run command
    logic [3:0] prof; // Ramp profile select
    logic [15:0] iv; // Initial voltage level
    logic [9:0] ic; // Initial current level
    logic [6:0] atime; // Accel ramp duration, s
    logic [9:0] clim; // Current limit setpoint
    logic [1:0] dmode; // Decel mode
    logic [6:0] dbeg; // Decel start level
    logic [6:0] doff; // Decel shut-off level
    logic [5:0] dtime; // Decel ramp duration, s
    ssr_pkg::ssr_state_e st; // Controller state
    logic [31:0] tcnt; // Tick prescaler
    logic [15:0] vref; // Voltage reference
    logic [15:0] cref; // Current reference, 10.6 percent
    logic [15:0] step; // Per-tick increment
    logic tripped; // Trip seen in decel
    logic [15:0] vout; // Registered voltage output
    logic fire; // Firing enable
    logic byp; // Bypass output
  } ssr_s;
  ssr_s q, d;
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Percent 0..100 to full-scale level
  function automatic logic [15:0] pct_lvl(input logic [6:0] p);
    logic [31:0] t;
    t = ({25'h0, p} * 32'h0000ffff) / 32'h00000064;
    return t[15:0];
  endfunction : pct_lvl
  // Step per tick so span is covered in secs seconds, rounded up
  function automatic logic [15:0] rate(input logic [15:0] span, input logic [6:0] secs);
    logic [31:0] n;
    logic [31:0] s;
    n = {25'h0, secs} * ssr_pkg::TICKS_PER_S;
    s = ({16'h0, span} + n - 32'h1) / ((n == 32'h0) ? 32'h1 : n);
    return (s == 32'h0) ? 16'h0001 : s[15:0];
  endfunction : rate
  // Current-ramp profile decode
  function automatic logic is_cur(input logic [3:0] p);
    return (p == ssr_pkg::PROF_C2) || (p == ssr_pkg::PROF_C4);
  endfunction : is_cur
  logic wr, tick, spd, ol, lim_on, over_lim;
  logic [15:0] vstep; // Voltage step of the current loop
  logic [15:0] dbeg_l, doff_l;
  logic [15:0] cl_fix;
  logic [15:0] cur_fix;
  assign spd = q.spd_s[1];
  assign ol = q.ol_s[1];
  // Write lands on the edge at which the master samples ack high
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && q.ack;
  assign tick = (q.tcnt >= TICK_CYCLES - 1);
  assign dbeg_l = pct_lvl(q.dbeg);
  assign doff_l = pct_lvl(q.doff);
  assign cl_fix = {q.clim, 6'h00};
  assign cur_fix = {motor_cur_i, 6'h00};
  // Limiting disabled at maximum setpoint, and once at speed
  assign lim_on = (q.clim < ssr_pkg::CL_MAX_PCT);
  assign over_lim = lim_on && (motor_cur_i >= q.clim);
  // Loop gain: voltage must move faster than the current reference climbs,
  // otherwise the measured current lags and the ramp stretches
  assign vstep = (q.step > (ssr_pkg::LVL_FULL >> 4)) ? ssr_pkg::LVL_FULL : {q.step[11:0], 4'h0};
  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    d.spd_s = {q.spd_s[0], at_speed_i};
    d.ol_s = {q.ol_s[0], overload_i};
    d.tcnt = tick ? 32'h0 : q.tcnt + 32'h1;
    // Bus: one-cycle ack, dropped after each beat
    d.ack = wb_cyc_i && wb_stb_i && !q.ack;
    if (wr) begin
      unique case (wb_adr_i)
        ssr_pkg::A_CTRL: begin
          if (wb_sel_i[0]) begin
            d.run = wb_dat_i[ssr_pkg::F_RUN] && !wb_dat_i[ssr_pkg::F_STOP];
            d.prof = wb_dat_i[ssr_pkg::F_PROF +: 4];
          end
        end
        ssr_pkg::A_INIT: begin
          d.iv = wb_dat_i[15:0];
          d.ic = wb_dat_i[25:16];
        end
        ssr_pkg::A_ACCEL: begin
          d.atime = (wb_dat_i[6:0] == 7'h0) ? 7'h01 : wb_dat_i[6:0];
          // Setpoint clamped into 200..600
          if (wb_dat_i[25:16] < ssr_pkg::CL_MIN_PCT) d.clim = ssr_pkg::CL_MIN_PCT;
          else if (wb_dat_i[25:16] > ssr_pkg::CL_MAX_PCT) d.clim = ssr_pkg::CL_MAX_PCT;
          else d.clim = wb_dat_i[25:16];
        end
        ssr_pkg::A_DECEL: begin
          // Out-of-range mode ignored
          if (wb_dat_i[1:0] <= ssr_pkg::DM_FORCE) d.dmode = wb_dat_i[1:0];
          if (wb_dat_i[14:8] <= ssr_pkg::PCT_FULL[6:0]) d.dbeg = wb_dat_i[14:8];
          if (wb_dat_i[22:16] < d.dbeg) d.doff = wb_dat_i[22:16];
          else d.doff = (d.dbeg == 7'h0) ? 7'h0 : d.dbeg - 7'h1;
          if (wb_dat_i[29:24] < ssr_pkg::DTIME_MIN) d.dtime = ssr_pkg::DTIME_MIN;
          else if (wb_dat_i[29:24] > ssr_pkg::DTIME_MAX) d.dtime = ssr_pkg::DTIME_MAX;
          else d.dtime = wb_dat_i[29:24];
        end
        default: begin
          d.run = q.run; // Unmapped write dropped
        end
      endcase
    end
    // Read mux, unmapped reads as zero
    unique case (wb_adr_i)
      ssr_pkg::A_CTRL: d.rdat = {24'h0, q.prof, 3'h0, q.run};
      ssr_pkg::A_INIT: d.rdat = {6'h0, q.ic, q.iv};
      ssr_pkg::A_ACCEL: d.rdat = {6'h0, q.clim, 9'h0, q.atime};
      ssr_pkg::A_DECEL: d.rdat = {2'h0, q.dtime, 1'b0, q.doff, 1'b0, q.dbeg, 6'h0, q.dmode};
      ssr_pkg::A_STAT: d.rdat = {24'h0, q.tripped, ol, spd, q.byp, q.fire, 3'(q.st)};
      ssr_pkg::A_REF: d.rdat = {q.cref, q.vref};
      default: d.rdat = 32'h0;
    endcase
    // Controller
    unique case (q.st)
      ssr_pkg::SSR_IDLE: begin
        d.fire = 1'b0;
        d.byp = 1'b0;
        d.tripped = 1'b0;
        d.vref = ssr_pkg::LVL_ZERO;
        if (q.run && !ol) begin
          d.st = ssr_pkg::SSR_RAMP;
          d.fire = 1'b1;
          d.vref = q.iv;
          d.cref = {q.ic, 6'h00};
          // Slope spans initial to limit or full in ramp time
          d.step = is_cur(q.prof) ? rate(cl_fix - {q.ic, 6'h00}, q.atime)
                                  : rate(ssr_pkg::LVL_FULL - q.iv, q.atime);
        end
      end
      ssr_pkg::SSR_RAMP, ssr_pkg::SSR_LIMIT: begin
        if (!q.run || ol) begin
          d.st = (q.dmode == ssr_pkg::DM_OFF || ol) ? ssr_pkg::SSR_IDLE : ssr_pkg::SSR_DECEL;
          d.vref = (d.st == ssr_pkg::SSR_DECEL) ? dbeg_l : ssr_pkg::LVL_ZERO;
          d.step = rate(dbeg_l - doff_l, {1'b0, q.dtime});
        end else if (spd) begin
          d.st = ssr_pkg::SSR_RUN;
          d.vref = ssr_pkg::LVL_FULL;
          d.byp = 1'b1;
        end else if (over_lim) begin
          d.st = ssr_pkg::SSR_LIMIT;
          // Back off voltage to hold current at limit
          if (tick && q.vref > q.step) d.vref = q.vref - q.step;
        end else if (tick) begin
          d.st = ssr_pkg::SSR_RAMP;
          if (is_cur(q.prof)) begin
            // Current reference climbs, voltage chases it
            // Reference stops at the setpoint, also with limiting off
            if ({1'b0, q.cref} + {1'b0, q.step} >= {1'b0, cl_fix}) d.cref = cl_fix;
            else d.cref = q.cref + q.step;
            if (cur_fix < q.cref) d.vref = (q.vref > ssr_pkg::LVL_FULL - vstep) ? ssr_pkg::LVL_FULL
                                                                             : q.vref + vstep;
            else if (q.vref > vstep) d.vref = q.vref - vstep;
          end else begin
            d.vref = (q.vref > ssr_pkg::LVL_FULL - q.step) ? ssr_pkg::LVL_FULL : q.vref + q.step;
          end
        end
      end
      ssr_pkg::SSR_RUN: begin
        if (!q.run || ol) begin
          d.byp = 1'b0;
          d.st = (q.dmode == ssr_pkg::DM_OFF || (ol && q.dmode == ssr_pkg::DM_PROT)) ? ssr_pkg::SSR_IDLE
                                                                                 : ssr_pkg::SSR_DECEL;
          d.vref = (d.st == ssr_pkg::SSR_DECEL) ? dbeg_l : ssr_pkg::LVL_ZERO;
          d.fire = (d.st == ssr_pkg::SSR_DECEL);
          d.step = rate(dbeg_l - doff_l, {1'b0, q.dtime});
        end
      end
      ssr_pkg::SSR_DECEL: begin
        d.byp = 1'b0;
        if (ol) d.tripped = 1'b1;
        if (ol && q.dmode == ssr_pkg::DM_PROT) begin
          d.st = ssr_pkg::SSR_IDLE;
          d.vref = ssr_pkg::LVL_ZERO;
          d.fire = 1'b0;
        end else if (q.vref <= doff_l) begin
          d.st = ssr_pkg::SSR_IDLE;
          d.vref = ssr_pkg::LVL_ZERO;
          d.fire = 1'b0;
        end else if (tick) begin
          d.vref = (q.vref < doff_l + q.step) ? doff_l : q.vref - q.step;
        end
      end
      default: d.st = ssr_pkg::SSR_IDLE;
    endcase
    d.vout = d.fire ? d.vref : ssr_pkg::LVL_ZERO;
  end
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.prof <= ssr_pkg::PROF_V1;
      q.iv <= ssr_pkg::IV_DEF;
      q.ic <= ssr_pkg::IC_DEF;
      q.atime <= ssr_pkg::ATIME_DEF;
      q.clim <= ssr_pkg::CL_DEF;
      q.dmode <= ssr_pkg::DM_OFF;
      q.dbeg <= ssr_pkg::DBEG_DEF;
      q.doff <= ssr_pkg::DOFF_DEF;
      q.dtime <= ssr_pkg::DTIME_DEF;
      q.st <= ssr_pkg::SSR_IDLE;
    end else begin
      q <= d;
    end
  end
  assign wb_dat_o = q.rdat;
  assign wb_ack_o = q.ack;
  assign volt_ref_o = q.vout;
  assign fire_en_o = q.fire;
  assign bypass_o = q.byp;
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  limit_floor_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) q.clim >= ssr_pkg::CL_MIN_PCT)
    else $error("current limit below floor");
  shutoff_order_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (q.dbeg == 7'h0) || (q.doff < q.dbeg))
    else $error("shut-off not below begin level");
  dmode_range_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) q.dmode <= ssr_pkg::DM_FORCE)
    else $error("decel mode out of range");
  bypass_open_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (q.st == ssr_pkg::SSR_RUN && !q.run) |=> !q.byp)
    else $error("bypass not opened on stop");
  stop_nodecel_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (q.st == ssr_pkg::SSR_RUN && !q.run && q.dmode == ssr_pkg::DM_OFF) |=> (q.st == ssr_pkg::SSR_IDLE && !q.fire))
    else $error("output not removed with decel off");
  trip_coast_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (q.st == ssr_pkg::SSR_DECEL && ol && q.dmode == ssr_pkg::DM_PROT) |=> !q.fire)
    else $error("no coast on trip in mode 1");
  force_decel_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (q.st == ssr_pkg::SSR_DECEL && q.dmode == ssr_pkg::DM_FORCE && q.vref > doff_l) |=> q.st == ssr_pkg::SSR_DECEL)
    else $error("forced decel ended early");
  decel_begin_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (q.st != ssr_pkg::SSR_DECEL ##1 q.st == ssr_pkg::SSR_DECEL) |-> q.vref == dbeg_l)
    else $error("decel not at begin level");
  speed_cut_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (q.st == ssr_pkg::SSR_RAMP && spd && q.run && !ol) |=> (q.st == ssr_pkg::SSR_RUN && q.byp))
    else $error("ramp not cut at speed");
  ramp_start_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (q.st == ssr_pkg::SSR_IDLE && q.run && !ol) |=> q.vref == $past(q.iv))
    else $error("ramp not at initial level");
  start_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i) q.st == ssr_pkg::SSR_RAMP ##1 q.st == ssr_pkg::SSR_RUN);
  limit_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i) q.st == ssr_pkg::SSR_LIMIT);
  decel_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i) q.st == ssr_pkg::SSR_DECEL ##1 q.st == ssr_pkg::SSR_IDLE);
  trip_force_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    q.st == ssr_pkg::SSR_DECEL && ol && q.dmode == ssr_pkg::DM_FORCE);
endmodule : ssr_top
`default_nettype wire

// [sim/ssr_motor_model.sv]
`timescale 1ns/100ps
`default_nettype none
// Motor and power stage as the ramp controller sees them
module ssr_motor_model (
  input wire logic mclk_i, // System clock
  input wire logic rst_n_i, // Async reset, active low
  input wire logic [15:0] volt_ref_i, // Voltage reference from the controller
  input wire logic fire_en_i, // Thyristors firing
  input wire logic bypass_i, // Bypass contactor closed
  input wire logic hold_i, // Bench keeps the rotor below speed
  output logic [9:0] cur_o, // Motor current, percent of full load
  output logic at_speed_o // Speed detector output
);
  logic [7:0] spd_q; // Crude rotor speed

  // ---------------------------------------------------------------
  // Rotor speed
  // ---------------------------------------------------------------
  // Unpowered rotor stops at once, so each start begins from rest
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      spd_q <= 8'h00;
    end else if (!fire_en_i && !bypass_i) begin // Coasting
      spd_q <= 8'h00;
    end else if (!hold_i && spd_q != 8'hff) begin // Powered and free
      spd_q <= spd_q + 8'h01;
    end
  end

  // Detector only reports while power is applied
  assign at_speed_o = (spd_q >= 8'h40) && (fire_en_i || bypass_i);

  // ---------------------------------------------------------------
  // Current draw
  // ---------------------------------------------------------------
  // Locked rotor draws in step with voltage, 600 percent at full
  always_comb begin
    if (!fire_en_i && !bypass_i) begin // No power, no current
      cur_o = 10'h000;
    end else if (at_speed_o) begin // Running load
      cur_o = 10'h064;
    end else begin // Accelerating
      cur_o = 10'((32'(volt_ref_i) * 32'd600) >> 16);
    end
  end
endmodule : ssr_motor_model
`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench for the soft start ramp controller
module tb;
  localparam int TICKS = 4; // Shortened ramp tick
  localparam int SEC = 1000 * TICKS; // Cycles per programmed second
  logic mclk = 1'b0, rst_n = 1'b0, we = 1'b0, cyc = 1'b0, stb = 1'b0;
  logic [7:0] adr = 8'h00; // Bus address
  logic [31:0] wdat = 32'h0, r; // Write data, last read data
  logic [3:0] sel = 4'h0; // Byte lanes
  logic overload = 1'b0, hold = 1'b1; // Trip pin, rotor brake
  wire logic [31:0] rd_o;
  wire logic ack, at_speed, fire, bypass;
  wire logic [15:0] vref;
  wire logic [9:0] cur;
  int error_cnt = 0, samples_checked = 0, n, mx;
  logic [15:0] iv; // Random initial voltage
  logic [9:0] cl; // Random current limit
  logic [6:0] beg; // Random begin level

  always #20 mclk = ~mclk; // 25 MHz

  ssr_top #(.TICK_CYCLES(TICKS)) ssr_top_i (.mclk_i(mclk), .rst_n_i(rst_n), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rd_o),
    .wb_ack_o(ack), .at_speed_i(at_speed), .overload_i(overload), .motor_cur_i(cur),
    .volt_ref_o(vref), .fire_en_o(fire), .bypass_o(bypass));
  ssr_motor_model ssr_motor_model_i (.mclk_i(mclk), .rst_n_i(rst_n), .volt_ref_i(vref),
    .fire_en_i(fire), .bypass_i(bypass), .hold_i(hold), .cur_o(cur), .at_speed_o(at_speed));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Verdict and end of run
  task results;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  // Compare within a tolerance, unknowns always fail
  task cmp(input logic [31:0] got, input logic [31:0] exp, input int tol);
    int d;
    d = (got > exp) ? int'(got - exp) : int'(exp - got);
    samples_checked++;
    if (^got === 1'bx || d > tol) begin
      error_cnt++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // Classic single bus cycle, held until ack is sampled
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do begin
      @(posedge mclk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (k >= 50) error_cnt++; // No answer counts as a mismatch
    r = rd_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  // Bounded wait for fire or bypass to reach a level
  task wait_out(input bit on_fire, input logic lvl, input int lim);
    n = 0;
    while ((on_fire ? fire : bypass) !== lvl && n < lim) begin
      @(posedge mclk);
      n++;
    end
  endtask : wait_out

  // Program decel, initial levels, accel 1 s and limit, then run
  task start(input logic [3:0] p, input logic [15:0] v, input logic [9:0] c, input logic [6:0] b,
             input logic [1:0] m);
    wb(1'b1, 8'h0c, {2'b00, 6'h01, 1'b0, 7'h1e, 1'b0, b, 6'h00, m});
    wb(1'b1, 8'h04, {6'h00, 10'h064, v});
    wb(1'b1, 8'h08, {6'h00, c, 9'h000, 7'h01});
    wb(1'b1, 8'h00, {24'h0, p, 4'h1});
  endtask : start

  // Reach speed, then stop
  task finish_run(input logic [3:0] p);
    hold <= 1'b0;
    wait_out(1'b0, 1'b1, 400);
    wb(1'b1, 8'h00, {24'h0, p, 4'h2});
  endtask : finish_run

  // Begin level as a reference value
  function automatic logic [15:0] lvl(input logic [6:0] pct);
    return 16'((32'(pct) * 32'hffff) / 32'd100);
  endfunction : lvl

  // ---------------------------------------------------------------
  // Watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (60000) @(posedge mclk);
    error_cnt++;
    $display("watchdog expired");
    results();
  end

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(87636));
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    // Defaults, clamps, refused values, unmapped place
    wb(1'b0, 8'h00, 32'h0); cmp(r, 32'h10, 0);
    wb(1'b0, 8'h04, 32'h0); cmp(r, 32'h00642000, 0);
    wb(1'b0, 8'h0c, 32'h0); cmp(r, 32'h0a1e3c00, 0);
    wb(1'b1, 8'h0c, 32'h3f7f6503);
    wb(1'b0, 8'h0c, 32'h0); cmp(r, 32'h3c3b3c00, 0);
    wb(1'b1, 8'h0c, 32'h001e3c01);
    wb(1'b0, 8'h0c, 32'h0); cmp(r, 32'h011e3c01, 0);
    wb(1'b1, 8'h08, 32'h00640000);
    wb(1'b0, 8'h08, 32'h0); cmp(r, 32'h00c80001, 0);
    wb(1'b0, 8'h20, 32'h0); cmp(r, 32'h0, 0);
    $display("registers done");
    // Every profile code, start level, early at-speed, plain stop
    for (int p = 1; p <= 4; p++) begin
      iv = 16'h1000 + 16'($urandom_range(16'h2fff));
      start(4'(p), iv, 10'h258, 7'h3c, 2'h0);
      repeat (2) @(posedge mclk);
      cmp(fire, 1, 0);
      if (p == 1 || p == 3) cmp(vref, iv, 16'h0080);
      finish_run(4'(p));
      cmp(n, 100, 300);
      repeat (2) @(posedge mclk);
      cmp({fire, bypass, vref}, 0, 0);
      hold <= 1'b1;
      $display("profile %0d done", p);
    end
    // No limiting at 600: full output within the ramp time
    start(4'h1, 16'h2000, 10'h258, 7'h3c, 2'h0);
    n = 0;
    while (vref !== 16'hffff && n < 2 * SEC) begin
      @(posedge mclk);
      n++;
    end
    cmp(n, SEC, 80);
    cmp(cur, 600, 10);
    finish_run(4'h1);
    hold <= 1'b1;
    $display("full ramp done");
    // Voltage ramp held at the limit with no timeout
    cl = 10'd250 + 10'($urandom_range(100));
    start(4'h1, 16'h2000, cl, 7'h3c, 2'h0);
    mx = 0;
    repeat (3 * SEC) begin
      @(posedge mclk);
      if (int'(cur) > mx) mx = int'(cur);
    end
    cmp(mx, cl, 12);
    cmp({fire, bypass, vref == 16'hffff}, 32'h4, 0);
    wb(1'b0, 8'h10, 32'h0); cmp(r[2:0], 2, 0);
    finish_run(4'h1);
    cmp(n, 100, 300);
    hold <= 1'b1;
    $display("current limit done");
    // Current ramp rises linearly from 100 to the limit
    start(4'h2, 16'h2000, 10'd300, 7'h3c, 2'h0);
    repeat (SEC / 2) @(posedge mclk);
    cmp(cur, 200, 30);
    repeat (SEC / 2 + 40) @(posedge mclk);
    cmp(cur, 300, 15);
    finish_run(4'h2);
    hold <= 1'b1;
    $display("current ramp done");
    // Decel modes 1 and 2 with a trip in mid-decel
    for (int m = 1; m <= 2; m++) begin
      beg = 7'd40 + 7'($urandom_range(60));
      start(4'h1, 16'h2000, 10'h258, beg, 2'(m));
      finish_run(4'h1);
      repeat (2) @(posedge mclk);
      cmp(bypass, 0, 0);
      cmp(vref, lvl(beg), 16'h0200);
      repeat (400) @(posedge mclk);
      overload <= 1'b1;
      if (m == 1) begin
        wait_out(1'b1, 1'b0, 10);
        cmp(fire, 0, 0);
      end else begin
        repeat (20) @(posedge mclk);
        cmp(fire, 1, 0);
        wait_out(1'b1, 1'b0, 2 * SEC);
        cmp(n + 421, SEC, SEC / 20);
        cmp(vref, 0, 0);
      end
      overload <= 1'b0;
      hold <= 1'b1;
      repeat (20) @(posedge mclk);
      $display("decel mode %0d done", m);
    end
    results();
  end
endmodule : tb
`default_nettype wire
